/* File: rtl/pbtp_pkg.sv */
package pbtp_pkg;
  ////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PHY_CTRL = 8'h19; // phy_control_register
  localparam logic [7:0] IDX_TEN_SCR  = 8'h1a; // ten_meg_status_control
  localparam logic [7:0] IDX_EXT      = 8'h1b; // line_test_and_selftest
  localparam logic [7:0] IDX_IRQ_ST   = 8'h1c; // interrupt status, w1c
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1e; // interrupt mask
  localparam logic [7:0] ADDR_PHY_CTRL = {IDX_PHY_CTRL[5:0], 2'h0};
  localparam logic [7:0] ADDR_TEN_SCR  = {IDX_TEN_SCR[5:0], 2'h0};
  localparam logic [7:0] ADDR_EXT      = {IDX_EXT[5:0], 2'h0};
  localparam logic [7:0] ADDR_IRQ_ST   = {IDX_IRQ_ST[5:0], 2'h0};
  localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[5:0], 2'h0};
  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int TALLY_LSB = 8;   // selftest_error_tally 15:8
  localparam int TALLY_MSB = 15;
  localparam int CONT_BIT  = 5;   // selftest_continuous_transmit
  localparam int PATEN_BIT = 4;   // ten_meg_pattern_enable
  localparam int GAP_BIT   = 2;   // ten_meg_pattern_gap_select
  localparam int SEL_LSB   = 0;   // ten_meg_pattern_select 1:0
  localparam int SEL_MSB   = 1;
  localparam int START_BIT = 0;   // self-test start in phy control
  localparam int JAB_BIT   = 0;   // jabber_function_off
  localparam int IRQ_ERR   = 0;   // errored nibble seen
  localparam int IRQ_SAT   = 1;   // tally saturated
  localparam int IRQ_SEQ   = 2;   // test sequence finished
  localparam int IRQ_W     = 3;
  ////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic [7:0]       TALLY_RST = 8'h00;
  localparam logic [7:0]       TALLY_MAX = 8'hff;
  localparam logic [1:0]       SEL_RST   = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 3'h0;
  // pattern select codes
  localparam logic [1:0] PAT_END_ZERO   = 2'h0; // data then end variant zero
  localparam logic [1:0] PAT_END_ONE    = 2'h1; // data then end variant one
  localparam logic [1:0] PAT_LINK_PULSE = 2'h2; // normal_link_pulse
  localparam logic [1:0] PAT_ONES       = 2'h3; // constant ones, 10 MHz tone
  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int GAP10_NS      = 10000;
  localparam int GAP15_NS      = 15000;
  localparam int GAP10_CYC = (GAP10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP15_CYC = (GAP15_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_W     = 10;
  localparam logic [GAP_W-1:0] GAP10_LD = GAP_W'(GAP10_CYC - 1);
  localparam logic [GAP_W-1:0] GAP15_LD = GAP_W'(GAP15_CYC - 1);
  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_SEND = 2'b01,
    PG_GAP  = 2'b10
  } pbtp_pg_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pbtp_apb_req_type;

  typedef struct packed {
    logic [7:0]       tally;
    logic             cont;
    logic             paten;
    logic             gap_sel;
    logic [1:0]       sel;
    logic             start;
    logic             jab_off;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    pbtp_pg_type      pg;
    logic [GAP_W-1:0] gap_cnt;
    logic             seq_start;
    logic [31:0]      rdata;
  } pbtp_state_type;
endpackage

/* File: rtl/pbtp_top.sv */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - count errored nibbles while self-test runs
// - restarting self-test clears the tally
// - tally sticks at its maximum
// - continuous mode sends unbroken pseudo-random data
// - continuous mode needs self-test start set
// - bit 4 enables patterns, resets zero
// - bit 2 picks 15 or 10 us
// - select 00/01 send data with eop variants
// - select 10 link pulses, 11 ones
// - jabber-off control disables jabber function
module pbtp_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // receive checker, same clock
  input  wire logic        rx_nibble_valid,
  input  wire logic        rx_nibble_err,
  // 10 Mb/s pattern transmitter
  input  wire logic        seq_done,
  output logic             seq_start,
  output logic             pattern_active,
  output logic [1:0]       pattern_kind,
  // self-test transmit controls
  output logic             selftest_run,
  output logic             selftest_continuous_tx,
  output logic             jabber_function_off,
  // interrupt
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////////
  // state and bus decode
  pbtp_pkg::pbtp_state_type s_r;    // all registered state
  pbtp_pkg::pbtp_state_type s_nxt;  // next value of the state
  pbtp_pkg::pbtp_apb_req_type req;  // bundled bus request
  logic                       hit;      // address is mapped
  logic                       wr_en;    // write takes effect now
  logic                       rd_setup; // read setup cycle
  logic [31:0]                rd_mux;   // read data of the address
  logic                       restart;  // self-test started again
  logic                       count_en; // errored nibble seen
  logic [pbtp_pkg::IRQ_W-1:0] irq_ev;   // events this cycle
  logic [pbtp_pkg::IRQ_W-1:0] irq_clr;  // w1c bits written

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  // decode of the mapped word addresses
  // one decode feeds read data and slave error so the two always agree
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0;
    unique case (req.paddr)
      pbtp_pkg::ADDR_PHY_CTRL: begin
        rd_mux[pbtp_pkg::START_BIT] = s_r.start;
      end
      pbtp_pkg::ADDR_TEN_SCR: begin
        rd_mux[pbtp_pkg::JAB_BIT] = s_r.jab_off;
      end
      pbtp_pkg::ADDR_EXT: begin
        // reserved 7:6 and 3 stay zero
        // reserved read zero
        rd_mux[pbtp_pkg::TALLY_MSB:pbtp_pkg::TALLY_LSB] = s_r.tally;
        rd_mux[pbtp_pkg::CONT_BIT]  = s_r.cont;
        rd_mux[pbtp_pkg::PATEN_BIT] = s_r.paten;
        rd_mux[pbtp_pkg::GAP_BIT]   = s_r.gap_sel;
        rd_mux[pbtp_pkg::SEL_MSB:pbtp_pkg::SEL_LSB] = s_r.sel;
      end
      pbtp_pkg::ADDR_IRQ_ST: begin
        rd_mux[pbtp_pkg::IRQ_W-1:0] = s_r.irq_st;
      end
      pbtp_pkg::ADDR_IRQ_MASK: begin
        rd_mux[pbtp_pkg::IRQ_W-1:0] = s_r.irq_mask;
      end
      default: begin
        // unmapped address answers with an error
        hit = 1'b0;
      end
    endcase
  end

  // zero wait states: every access completes in its first access cycle
  // trade-off: read data is taken at setup, so an event in the access
  // cycle shows on the next read, not on this one
  assign pready   = 1'b1;
  assign pslverr  = req.psel & req.penable & ~hit;
  assign wr_en    = req.psel & req.penable & req.pwrite & hit;
  assign rd_setup = req.psel & ~req.penable & ~req.pwrite;

  //////////////////////////////////////////////////////////////////////////
  // events
  // only a 0 to 1 write of the start bit is a restart; writing one
  // again while running leaves the tally alone
  // restart clears tally
  assign restart  = wr_en & (req.paddr == pbtp_pkg::ADDR_PHY_CTRL) &
                    req.pwdata[pbtp_pkg::START_BIT] & ~s_r.start;
  assign count_en = s_r.start & rx_nibble_valid & rx_nibble_err;
  assign irq_ev[pbtp_pkg::IRQ_ERR] = count_en;
  // the saturation event fires once, on the step into the maximum
  assign irq_ev[pbtp_pkg::IRQ_SAT] = count_en & ~restart &
                                     (s_r.tally == pbtp_pkg::TALLY_MAX - 8'h01);
  assign irq_ev[pbtp_pkg::IRQ_SEQ] = (s_r.pg == pbtp_pkg::PG_SEND) & seq_done;
  assign irq_clr = (wr_en & (req.paddr == pbtp_pkg::ADDR_IRQ_ST)) ?
                   req.pwdata[pbtp_pkg::IRQ_W-1:0] : '0;

  //////////////////////////////////////////////////////////////////////////
  // next state
  // every field except seq_start, which drops to zero, holds unless one of the causes below changes it
  always_comb begin
    s_nxt = s_r;
    s_nxt.seq_start = 1'b0;
    // read data is caught in the setup cycle so it sits in a flop
    if (rd_setup) begin
      s_nxt.rdata = rd_mux;
    end
    // register writes; the tally field is not writable
    // tally ignores writes
    if (wr_en) begin
      unique case (req.paddr)
        pbtp_pkg::ADDR_PHY_CTRL: begin
          s_nxt.start = req.pwdata[pbtp_pkg::START_BIT];
        end
        pbtp_pkg::ADDR_TEN_SCR: begin
          s_nxt.jab_off = req.pwdata[pbtp_pkg::JAB_BIT];
        end
        pbtp_pkg::ADDR_EXT: begin
          s_nxt.cont    = req.pwdata[pbtp_pkg::CONT_BIT];
          s_nxt.paten   = req.pwdata[pbtp_pkg::PATEN_BIT];
          s_nxt.gap_sel = req.pwdata[pbtp_pkg::GAP_BIT];
          s_nxt.sel = req.pwdata[pbtp_pkg::SEL_MSB:pbtp_pkg::SEL_LSB];
        end
        pbtp_pkg::ADDR_IRQ_MASK: begin
          s_nxt.irq_mask = req.pwdata[pbtp_pkg::IRQ_W-1:0];
        end
        default: begin
          // status is cleared below, others have no write effect
        end
      endcase
    end
    // restart wins over a nibble error in the same cycle
    if (restart) begin
      s_nxt.tally = pbtp_pkg::TALLY_RST;
    end else if (count_en && s_r.tally != pbtp_pkg::TALLY_MAX) begin
      s_nxt.tally = s_r.tally + 8'h01;
    end
    // sticky status: a new event beats a clear in the same cycle
    s_nxt.irq_st = (s_r.irq_st & ~irq_clr) | irq_ev;
    // pattern sequencer: send, then idle for the chosen gap
    // the gap load is one below the cycle count because the cycle in
    // which the counter reads zero belongs to the gap too
    // limitation: seq_done outside a sending phase is dropped
    unique case (s_r.pg)
      pbtp_pkg::PG_IDLE: begin
        if (s_r.paten) begin
          s_nxt.pg = pbtp_pkg::PG_SEND;
          s_nxt.seq_start = 1'b1;
        end
      end
      pbtp_pkg::PG_SEND: begin
        if (seq_done) begin
          s_nxt.pg = pbtp_pkg::PG_GAP;
          s_nxt.gap_cnt = s_r.gap_sel ? pbtp_pkg::GAP15_LD
                                      : pbtp_pkg::GAP10_LD;
        end
      end
      pbtp_pkg::PG_GAP: begin
        if (s_r.gap_cnt == '0) begin
          s_nxt.pg = pbtp_pkg::PG_SEND;
          s_nxt.seq_start = 1'b1;
        end else begin
          s_nxt.gap_cnt = s_r.gap_cnt - 10'h001;
        end
      end
      default: begin
        s_nxt.pg = pbtp_pkg::PG_IDLE;
      end
    endcase
    // disabling patterns aborts any sequence at once
    if (!s_r.paten) begin
      s_nxt.pg = pbtp_pkg::PG_IDLE;
      s_nxt.seq_start = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  // synchronous reset loads constants only, so every field is defined
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{tally: pbtp_pkg::TALLY_RST, cont: 1'b0, paten: 1'b0,
               gap_sel: 1'b0, sel: pbtp_pkg::SEL_RST, start: 1'b0,
               jab_off: 1'b0, irq_st: pbtp_pkg::IRQ_RST,
               irq_mask: pbtp_pkg::IRQ_RST, pg: pbtp_pkg::PG_IDLE,
               gap_cnt: '0, seq_start: 1'b0, rdata: 32'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata    = s_r.rdata;
  assign seq_start = s_r.seq_start;
  // the transmitter shapes the pulses; these are plain register levels
  // select code: data with eop variants, link pulses or ones
  assign pattern_kind   = s_r.sel;
  assign pattern_active = s_r.paten;
  assign selftest_run   = s_r.start;
  // gated by start control
  // jabber must already be off for continuous 10 Mb/s use; that order is
  // kept by software, this block only holds the two controls
  assign selftest_continuous_tx = s_r.cont & s_r.start;
  assign jabber_function_off    = s_r.jab_off;
  assign irq = |(s_r.irq_st & s_r.irq_mask);

  //////////////////////////////////////////////////////////////////////////
  // checks
  // each property looks one edge after its cause, gap_short_a one and two edges after, on registered state
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence done_short_s;
    s_r.pg == pbtp_pkg::PG_SEND && seq_done && !s_r.gap_sel && s_r.paten;
  endsequence
  sequence done_long_s;
    s_r.pg == pbtp_pkg::PG_SEND && seq_done && s_r.gap_sel && s_r.paten;
  endsequence
  sequence gap_end_s;
    s_r.pg == pbtp_pkg::PG_GAP && s_r.gap_cnt == '0 && s_r.paten;
  endsequence
  sequence last_step_s;
    count_en && !restart && s_r.tally == pbtp_pkg::TALLY_MAX - 8'h01;
  endsequence

  tally_count_a: assert property (
    count_en && !restart && s_r.tally != pbtp_pkg::TALLY_MAX
    |=> s_r.tally == $past(s_r.tally) + 8'h01)
    else $error("tally did not step on errored nibble");

  tally_restart_a: assert property (
    restart |=> s_r.tally == 8'h00)
    else $error("tally not cleared on restart");

  tally_stick_a: assert property (
    s_r.tally == pbtp_pkg::TALLY_MAX && !restart
    |=> s_r.tally == pbtp_pkg::TALLY_MAX)
    else $error("tally left its maximum");

  cont_gate_a: assert property (
    wr_en && req.paddr == pbtp_pkg::ADDR_PHY_CTRL &&
    !req.pwdata[pbtp_pkg::START_BIT] |=> !selftest_continuous_tx)
    else $error("continuous transmit without start");

  gap_short_a: assert property (
    done_short_s |=> s_r.gap_cnt == pbtp_pkg::GAP10_LD ##1
    s_r.gap_cnt == pbtp_pkg::GAP10_LD - 10'h001 || !s_r.paten)
    else $error("short gap load wrong");

  gap_long_a: assert property (
    done_long_s |=> s_r.gap_cnt == pbtp_pkg::GAP15_LD && !seq_start)
    else $error("long gap load wrong");

  gap_end_a: assert property (
    gap_end_s |=> seq_start && s_r.pg == pbtp_pkg::PG_SEND)
    else $error("no sequence after gap");

  pat_off_a: assert property (
    !s_r.paten |=> s_r.pg == pbtp_pkg::PG_IDLE && !seq_start)
    else $error("sequencer active while disabled");

  jabber_wr_a: assert property (
    wr_en && req.paddr == pbtp_pkg::ADDR_TEN_SCR
    |=> jabber_function_off == $past(req.pwdata[pbtp_pkg::JAB_BIT]))
    else $error("jabber control not stored");

  tally_ro_a: assert property (
    wr_en && req.paddr == pbtp_pkg::ADDR_EXT && !count_en && !restart
    |=> $stable(s_r.tally))
    else $error("tally changed by write");

  rsvd_zero_a: assert property (
    rd_setup && req.paddr == pbtp_pkg::ADDR_EXT
    |=> prdata[7:6] == 2'h0 && prdata[3] == 1'b0 && prdata[31:16] == 16'h0)
    else $error("reserved bits read nonzero");

  set_wins_a: assert property (
    irq_ev[pbtp_pkg::IRQ_ERR] && irq_clr[pbtp_pkg::IRQ_ERR]
    |=> s_r.irq_st[pbtp_pkg::IRQ_ERR])
    else $error("event lost against clear");

  seq_pulse_a: assert property (
    seq_start |=> !seq_start)
    else $error("sequence start wider than one cycle");

  pat_on_a: assert property (
    $rose(pattern_active) |=> seq_start)
    else $error("no sequence after pattern enable");

  idle_count_a: assert property (
    !selftest_run && !restart |=> $stable(s_r.tally))
    else $error("tally moved while self-test stopped");

  tally_read_a: assert property (
    rd_setup && req.paddr == pbtp_pkg::ADDR_EXT
    |=> prdata[pbtp_pkg::TALLY_MSB:pbtp_pkg::TALLY_LSB] == $past(s_r.tally))
    else $error("tally read back wrong");

  sat_flag_a: assert property (
    last_step_s |=> s_r.tally == pbtp_pkg::TALLY_MAX &&
    s_r.irq_st[pbtp_pkg::IRQ_SAT])
    else $error("saturation not flagged");

  status_hold_a: assert property (
    s_r.irq_st[pbtp_pkg::IRQ_SAT] && !irq_clr[pbtp_pkg::IRQ_SAT]
    |=> s_r.irq_st[pbtp_pkg::IRQ_SAT])
    else $error("saturation flag lost without clear");

  ext_store_a: assert property (
    wr_en && req.paddr == pbtp_pkg::ADDR_EXT
    |=> pattern_active == $past(req.pwdata[pbtp_pkg::PATEN_BIT]) &&
    pattern_kind == $past(req.pwdata[pbtp_pkg::SEL_MSB:pbtp_pkg::SEL_LSB]))
    else $error("pattern controls not stored");

  gap_quiet_a: assert property (
    s_r.pg == pbtp_pkg::PG_GAP && s_r.gap_cnt != '0 |=> !seq_start)
    else $error("sequence started inside the gap");

  unmapped_a: assert property (
    psel && penable && pwrite && !hit
    |=> $stable(s_r.start) && $stable(s_r.irq_mask) && $stable(s_r.cont))
    else $error("write to unmapped address took effect");
endmodule // pbtp_top

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  //////////////////////////////////////////////////////////////////////////
  // design ports, every input valued at time zero
  logic        clk                    = 1'b0;
  logic        rst                    = 1'b1;
  logic        psel                   = 1'b0;
  logic        penable                = 1'b0;
  logic        pwrite                 = 1'b0;
  logic [7:0]  paddr                  = 8'h00;
  logic [31:0] pwdata                 = 32'h0;
  logic        rx_nibble_valid        = 1'b0;
  logic        rx_nibble_err          = 1'b0;
  logic        seq_done               = 1'b0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        seq_start;
  logic        pattern_active;
  logic [1:0]  pattern_kind;
  logic        selftest_run;
  logic        selftest_continuous_tx;
  logic        jabber_function_off;
  logic        irq;
  // bookkeeping
  int          fail_count             = 0;
  int          cmp_count              = 0;
  int          cyc                    = 0;
  logic [31:0] rd;                    // last read data
  logic        er;                    // last slave error

  // 40 MHz clock
  always #12.5 clk = ~clk;

  pbtp_top pbtp_top_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .rx_nibble_valid(rx_nibble_valid),
    .rx_nibble_err(rx_nibble_err), .seq_done(seq_done),
    .seq_start(seq_start), .pattern_active(pattern_active),
    .pattern_kind(pattern_kind), .selftest_run(selftest_run),
    .selftest_continuous_tx(selftest_continuous_tx),
    .jabber_function_off(jabber_function_off), .irq(irq));

  //////////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the hang guard
  task wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard: whole run needs under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; no wait count assumed, the guard ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // back-to-back nibbles, err qualifies each one
  task nibbles(input int n, input logic e);
    repeat (n) begin
      @(posedge clk);
      rx_nibble_valid <= 1'b1;
      rx_nibble_err   <= e;
    end
    @(posedge clk);
    rx_nibble_valid <= 1'b0;
    rx_nibble_err   <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // fields, reserved bits and pattern select codes
  task t_fields();
    rd_chk(pbtp_pkg::ADDR_EXT, 32'h0);
    for (int s = 0; s < 4; s++) begin
      // tally and reserved bits written as ones must not stick
      apb(1'b1, pbtp_pkg::ADDR_EXT, 32'h0000ffdc | 32'(s));
      rd_chk(pbtp_pkg::ADDR_EXT, 32'h14 | 32'(s));
      @(negedge clk);
      chk({31'h0, pattern_active}, 32'h1);
      chk({30'h0, pattern_kind}, 32'(s));
    end
    apb(1'b1, pbtp_pkg::ADDR_EXT, 32'h0);
    @(negedge clk);
    chk({31'h0, pattern_active}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'h40, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    rd_chk(pbtp_pkg::ADDR_EXT, 32'h0);
  endtask

  // continuous transmit needs the start bit; jabber turned off first
  task t_cont();
    apb(1'b1, pbtp_pkg::ADDR_EXT, 32'h20);
    @(negedge clk);
    chk({31'h0, selftest_continuous_tx}, 32'h0);
    apb(1'b1, pbtp_pkg::ADDR_TEN_SCR, 32'h1);
    @(negedge clk);
    chk({31'h0, jabber_function_off}, 32'h1);
    apb(1'b1, pbtp_pkg::ADDR_PHY_CTRL, 32'h1);
    @(negedge clk);
    chk({30'h0, selftest_run, selftest_continuous_tx}, 32'h3);
    apb(1'b1, pbtp_pkg::ADDR_PHY_CTRL, 32'h0);
    apb(1'b1, pbtp_pkg::ADDR_EXT, 32'h0);
    apb(1'b1, pbtp_pkg::ADDR_TEN_SCR, 32'h0);
    @(negedge clk);
    chk({31'h0, jabber_function_off}, 32'h0);
  endtask

  // tally counting, saturation, restart and the interrupt around it
  task t_tally();
    apb(1'b1, pbtp_pkg::ADDR_IRQ_MASK, 32'h7);
    apb(1'b1, pbtp_pkg::ADDR_PHY_CTRL, 32'h1);
    nibbles(5, 1'b1);
    nibbles(3, 1'b0);
    rd_chk(pbtp_pkg::ADDR_EXT, 32'h0500);
    chk({31'h0, irq}, 32'h1);
    rd_chk(pbtp_pkg::ADDR_IRQ_ST, 32'h1);
    apb(1'b1, pbtp_pkg::ADDR_IRQ_ST, 32'h1);
    rd_chk(pbtp_pkg::ADDR_IRQ_ST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // far past 255 so a wrap would show
    nibbles(300, 1'b1);
    rd_chk(pbtp_pkg::ADDR_EXT, 32'hff00);
    rd_chk(pbtp_pkg::ADDR_IRQ_ST, 32'h3);
    apb(1'b1, pbtp_pkg::ADDR_IRQ_ST, 32'h3);
    apb(1'b1, pbtp_pkg::ADDR_PHY_CTRL, 32'h0);
    apb(1'b1, pbtp_pkg::ADDR_PHY_CTRL, 32'h1);
    rd_chk(pbtp_pkg::ADDR_EXT, 32'h0);
    // masked source must keep the line low
    apb(1'b1, pbtp_pkg::ADDR_IRQ_MASK, 32'h0);
    nibbles(1, 1'b1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(pbtp_pkg::ADDR_IRQ_ST, 32'h1);
    // a clear in the same cycle as a nibble error loses to the error
    fork
      nibbles(2, 1'b1);
      apb(1'b1, pbtp_pkg::ADDR_IRQ_ST, 32'h1);
    join
    rd_chk(pbtp_pkg::ADDR_IRQ_ST, 32'h1);
    apb(1'b1, pbtp_pkg::ADDR_IRQ_ST, 32'h7);
    apb(1'b1, pbtp_pkg::ADDR_PHY_CTRL, 32'h0);
    // a stopped self-test must not count
    nibbles(2, 1'b1);
    rd_chk(pbtp_pkg::ADDR_EXT, 32'h0300);
  endtask

  // gap between sequences, measured from seq_done to the next start
  task t_gap(input logic g);
    int n;
    apb(1'b1, pbtp_pkg::ADDR_EXT, 32'h10 | {29'h0, g, 2'h0});
    n = 0;
    while (seq_start !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, seq_start}, 32'h1);
    @(posedge clk);
    seq_done <= 1'b1;
    @(posedge clk);
    seq_done <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (seq_start !== 1'b1 && n < 1000);
    if (g)
      chk(32'(n), 32'(pbtp_pkg::GAP15_CYC + 1));
    else
      chk(32'(n), 32'(pbtp_pkg::GAP10_CYC + 1));
    rd_chk(pbtp_pkg::ADDR_IRQ_ST, 32'h4);
    apb(1'b1, pbtp_pkg::ADDR_EXT, 32'h0);
    apb(1'b1, pbtp_pkg::ADDR_IRQ_ST, 32'h7);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_fields();
    t_cont();
    t_tally();
    t_gap(1'b0);
    t_gap(1'b1);
    wrap_up();
  end
endmodule // tb_top
